// >>> logic/ocp_pkg.sv
// Purpose: Shared constants and types for the output compare and PWM channel.
// Assumes: 10 MHz clock, four clocks per instruction cycle.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package ocp_pkg;
   // Clock timing; one timebase count lasts one instruction cycle.
   localparam int CLK_NS = 100;
   localparam int TCY_NS = 400;
   localparam int CLK_PER_TCY = TCY_NS / CLK_NS;
   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_PRI = 8'h08;
   localparam logic [7:0] OFF_SEC = 8'h0c;
   localparam logic [7:0] OFF_PER = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   // Control one fields.
   localparam int C1_MODE_LSB = 0;
   localparam int C1_TRIG_CLR = 3;
   localparam int C1_FSTAT_LSB = 4;
   localparam int C1_FEN_LSB = 7;
   localparam logic [15:0] C1_MASK = 16'h3fff;
   localparam logic [15:0] C1_RESET = 16'h0000;
   // Control two fields.
   localparam int C2_SYNC_LSB = 0;
   localparam int C2_TRIS = 5;
   localparam int C2_TRIG_STAT = 6;
   localparam int C2_TRIG_SEL = 7;
   localparam int C2_CASCADE = 8;
   localparam int C2_DCB_LSB = 9;
   localparam int C2_INV = 12;
   localparam int C2_FORCE = 13;
   localparam int C2_FLT_LVL = 14;
   localparam int C2_HOLD = 15;
   localparam logic [15:0] C2_MASK = 16'hf7ff;
   localparam logic [15:0] C2_RESET = 16'h000c;
   // Status register fields.
   localparam int ST_PIN = 16;
   localparam int ST_FAULT = 17;
   // Source select codes.
   localparam logic [4:0] SYNC_NONE = 5'h00;
   localparam logic [4:0] SYNC_OC_FIRST = 5'h01;
   localparam logic [4:0] SYNC_OC_LAST = 5'h06;
   localparam logic [4:0] SYNC_TMR_FIRST = 5'h0b;
   localparam logic [4:0] SYNC_TMR_LAST = 5'h0f;
   localparam logic [4:0] SYNC_IC_FIRST = 5'h10;
   localparam logic [4:0] SYNC_IC_LAST = 5'h15;
   localparam logic [4:0] SYNC_CMP_FIRST = 5'h18;
   localparam logic [4:0] SYNC_CMP_LAST = 5'h1a;
   localparam logic [4:0] SYNC_ADC = 5'h1b;
   localparam logic [4:0] SYNC_CTMU = 5'h1c;
   localparam logic [4:0] SYNC_EXT2 = 5'h1d;
   localparam logic [4:0] SYNC_EXT1 = 5'h1e;
   localparam logic [4:0] SYNC_SELF = 5'h1f;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Compare modes.
   typedef enum logic [2:0] {
      M_OFF = 3'h0,
      M_SS_RISE = 3'h1,
      M_SS_FALL = 3'h2,
      M_TOGGLE = 3'h3,
      M_DC_ONE = 3'h4,
      M_DC_CONT = 3'h5,
      M_PWM_EDGE = 3'h6,
      M_PWM_CTR = 3'h7
   } ocp_mode_t;
   // Double compare phases, Gray coded.
   typedef enum logic [1:0] {
      DC_IDLE = 2'b00,
      DC_WAIT_PRI = 2'b01,
      DC_WAIT_SEC = 2'b11,
      DC_DONE = 2'b10
   } ocp_dc_t;
   // Trigger and sync event sources from the rest of the chip.
   typedef struct packed {
      logic [5:0] oc;
      logic [5:0] ic;
      logic [4:0] tmr;
      logic [2:0] cmp;
      logic adc;
      logic ctmu;
      logic ext1;
      logic ext2;
   } ocp_src_t;
endpackage

// >>> logic/ocp_channel.sv
// Purpose: One output compare and PWM channel with AXI4-Lite registers.
// Assumes: Synchronous inputs; event sources are one-cycle pulses.
// Notes: The timebase advances once per instruction cycle of four clocks.
`timescale 1ns/1ps
`default_nettype none
module ocp_channel #(
   parameter int CHAN = 1
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [7:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire ocp_pkg::ocp_src_t i_src,
   input wire logic i_fault_pin_a,
   input wire logic i_fault_pin_b,
   output logic o_compare_output_pin,
   output logic o_compare_output_pin_oe,
   output logic o_compare_irq_flag,
   output logic o_period_event,
   output logic o_cascade_enable
);
   import ocp_pkg::*;

   // Refuse channel numbers without a comparator pairing.
   if (CHAN < 1 || CHAN > 6) begin : g_bad_chan
      $error("CHAN must lie between 1 and 6");
   end
   localparam logic [1:0] CMP_IDX = 2'((CHAN - 1) / 2);

   // Maps a byte address to a register index, 7 when unmapped.
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      case (a)
         OFF_CTRL1: reg_index = 3'h0;
         OFF_CTRL2: reg_index = 3'h1;
         OFF_PRI: reg_index = 3'h2;
         OFF_SEC: reg_index = 3'h3;
         OFF_PER: reg_index = 3'h4;
         OFF_STAT: reg_index = 3'h5;
         default: reg_index = 3'h7;
      endcase
   endfunction

   // Applies the two low byte strobes to a 16-bit register.
   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      wmerge = v & m;
   endfunction

   // Picks the event of the selected source.
   function automatic logic sel_event(input logic [4:0] c, input ocp_src_t s, input logic self_ev);
      sel_event = 1'b0;
      if (c >= SYNC_OC_FIRST && c <= SYNC_OC_LAST) sel_event = s.oc[3'(c - SYNC_OC_FIRST)];
      else if (c >= SYNC_TMR_FIRST && c <= SYNC_TMR_LAST) sel_event = s.tmr[3'(c - SYNC_TMR_FIRST)];
      else if (c >= SYNC_IC_FIRST && c <= SYNC_IC_LAST) sel_event = s.ic[3'(c - SYNC_IC_FIRST)];
      else if (c >= SYNC_CMP_FIRST && c <= SYNC_CMP_LAST) sel_event = s.cmp[2'(c - SYNC_CMP_FIRST)];
      else if (c == SYNC_ADC) sel_event = s.adc;
      else if (c == SYNC_CTMU) sel_event = s.ctmu;
      else if (c == SYNC_EXT1) sel_event = s.ext1;
      else if (c == SYNC_EXT2) sel_event = s.ext2;
      else if (c == SYNC_SELF) sel_event = self_ev;
   endfunction

   logic [15:0] ctrl1_reg, ctrl2_reg, pri_reg, sec_reg, per_reg;
   logic [15:0] tb_reg, pri_lat_reg, sec_lat_reg;
   logic [1:0] q_reg, dcb_lat_reg;
   logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg, reinit_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic comp_reg, fault_reg, pin_reg, oe_reg, irq_reg, per_ev_reg;
   ocp_dc_t dc_reg;
   ocp_mode_t mode;
   logic do_wr, wr_c1, wr_c2, pwm, trig_mode, run, tick, per_hit, pri_hit, sec_hit;
   logic src_ev, pwm_wave;
   logic [2:0] wr_idx, fsrc, new_flt;

   // Decoded control fields and compare events.
   // A tick marks the last clock of a timebase count; every match acts on it.
   assign mode = ocp_mode_t'(ctrl1_reg[C1_MODE_LSB +: 3]);
   assign pwm = (mode == M_PWM_EDGE) || (mode == M_PWM_CTR);
   assign trig_mode = ctrl2_reg[C2_TRIG_SEL];
   assign run = (mode != M_OFF) && (!trig_mode || ctrl2_reg[C2_TRIG_STAT]);
   assign tick = run && (q_reg == 2'(CLK_PER_TCY - 1));
   assign per_hit = tick && (tb_reg == per_reg);
   assign pri_hit = tick && (tb_reg == pri_reg);
   assign sec_hit = tick && (tb_reg == sec_reg);
   assign src_ev = sel_event(ctrl2_reg[C2_SYNC_LSB +: 5], i_src, per_hit);

   // Write channel: address and data are held independently, then applied together.
   // Either may come first; a second write waits until the last answer is taken,
   // so a held response is never overwritten.
   assign wr_idx = reg_index(awaddr_reg);
   assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_c1 = do_wr && (wr_idx == 3'h0);
   assign wr_c2 = do_wr && (wr_idx == 3'h1);
   assign o_awready = !aw_hold_reg;
   assign o_wready = !w_hold_reg;
   assign o_bvalid = bvalid_reg;
   assign o_bresp = bresp_reg;
   assign o_arready = !rvalid_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rdata = rdata_reg;
   assign o_rresp = rresp_reg;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (i_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= i_awaddr;
         end
         if (i_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
         end
         if (do_wr) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_reg && i_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read channel answers one cycle after the address is taken.
   // The address is refused while an answer stands, so read data stays put
   // for a master that is slow to raise rready.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (i_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         case (reg_index(i_araddr))
            3'h0: rdata_reg <= {16'h0000, ctrl1_reg};
            3'h1: rdata_reg <= {16'h0000, ctrl2_reg};
            3'h2: rdata_reg <= {16'h0000, pri_reg};
            3'h3: rdata_reg <= {16'h0000, sec_reg};
            3'h4: rdata_reg <= {16'h0000, per_reg};
            3'h5: rdata_reg <= {14'h0000, fault_reg, pin_reg, tb_reg};
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && i_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Compare values and period are plain storage.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pri_reg <= 16'h0000;
         sec_reg <= 16'h0000;
         per_reg <= 16'h0000;
      end else if (do_wr) begin
         if (wr_idx == 3'h2) pri_reg <= wmerge(pri_reg, wdata_reg, wstrb_reg, 16'hffff);
         if (wr_idx == 3'h3) sec_reg <= wmerge(sec_reg, wdata_reg, wstrb_reg, 16'hffff);
         if (wr_idx == 3'h4) per_reg <= wmerge(per_reg, wdata_reg, wstrb_reg, 16'hffff);
      end
   end

   // Fault sources: pin A, pin B and the comparator paired with this channel.
   // The other comparators cannot trip this channel.
   assign fsrc = {i_src.cmp[CMP_IDX], i_fault_pin_b, i_fault_pin_a};
   assign new_flt = fsrc & ctrl1_reg[C1_FEN_LSB +: 3] & {3{pwm}};

   // Control one; a fault arriving with a software clear still sets its bit.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl1_reg <= C1_RESET;
      end else if (wr_c1) begin
         ctrl1_reg <= wmerge(ctrl1_reg, wdata_reg, wstrb_reg, C1_MASK) | {9'h000, new_flt, 4'h0};
      end else begin
         ctrl1_reg[C1_FSTAT_LSB +: 3] <= ctrl1_reg[C1_FSTAT_LSB +: 3] | new_flt;
      end
   end

   // Control two; the trigger event wins over any clear in the same cycle.
   // Trigger status only gates the timebase while trigger mode is selected.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl2_reg <= C2_RESET;
      end else begin
         if (wr_c2) begin
            ctrl2_reg <= wmerge(ctrl2_reg, wdata_reg, wstrb_reg, C2_MASK);
         end else if (ctrl1_reg[C1_TRIG_CLR] && sec_hit) begin
            ctrl2_reg[C2_TRIG_STAT] <= 1'b0;
         end
         if (trig_mode && src_ev) ctrl2_reg[C2_TRIG_STAT] <= 1'b1;
      end
   end

   // Timebase: one count per instruction cycle, wrapping after period plus one counts.
   // It stands at zero while off or waiting for a trigger, so a run
   // always begins with a full first period.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tb_reg <= 16'h0000;
         q_reg <= 2'h0;
      end else if (!run) begin
         tb_reg <= 16'h0000;
         q_reg <= 2'h0;
      end else if (!trig_mode && src_ev && ctrl2_reg[C2_SYNC_LSB +: 5] != SYNC_SELF) begin
         tb_reg <= 16'h0000;
         q_reg <= 2'h0;
      end else begin
         q_reg <= q_reg + 2'h1;
         if (tick) tb_reg <= (tb_reg == per_reg) ? 16'h0000 : tb_reg + 16'h0001;
      end
   end

   // PWM duty buffer loads at the period match; outside PWM it follows the registers.
   // Software may write duty values at any time; loading them only here keeps
   // a half-updated pair off the pin.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pri_lat_reg <= 16'h0000;
         sec_lat_reg <= 16'h0000;
         dcb_lat_reg <= 2'h0;
      end else if (!pwm || per_hit) begin
         pri_lat_reg <= pri_reg;
         sec_lat_reg <= sec_reg;
         dcb_lat_reg <= ctrl2_reg[C2_DCB_LSB +: 2];
      end
   end

   // PWM wave; the falling edge stretches by one clock per quarter of the fraction.
   always_comb begin
      pwm_wave = (tb_reg < sec_lat_reg) || (tb_reg == sec_lat_reg && q_reg < dcb_lat_reg);
      if (mode == M_PWM_CTR) pwm_wave = pwm_wave && (tb_reg >= pri_lat_reg);
   end

   // Start a fresh sequence whenever control one is written.
   // The restart lands one clock later, once the new mode is in place.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) reinit_reg <= 1'b0;
      else reinit_reg <= wr_c1;
   end

   // Single and double compare sequences.
   // Single-shot modes hold their level after the transition, though the flag
   // still pulses at each primary match; rewriting control one rearms them.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         comp_reg <= 1'b0;
         dc_reg <= DC_IDLE;
      end else if (reinit_reg) begin
         comp_reg <= (mode == M_SS_FALL);
         dc_reg <= (mode == M_DC_ONE || mode == M_DC_CONT) ? DC_WAIT_PRI : DC_IDLE;
      end else begin
         case (mode)
            M_SS_RISE: if (pri_hit) comp_reg <= 1'b1;
            M_SS_FALL: if (pri_hit) comp_reg <= 1'b0;
            M_TOGGLE: if (pri_hit) comp_reg <= !comp_reg;
            M_DC_ONE, M_DC_CONT: begin
               if (dc_reg == DC_WAIT_PRI && pri_hit) begin
                  comp_reg <= 1'b1;
                  dc_reg <= DC_WAIT_SEC;
               end else if (dc_reg == DC_WAIT_SEC && sec_hit) begin
                  comp_reg <= 1'b0;
                  dc_reg <= (mode == M_DC_CONT) ? DC_WAIT_PRI : DC_DONE;
               end
            end
            default: comp_reg <= 1'b0;
         endcase
      end
   end

   // Fault mode entry and exit.
   // A new fault beats every exit path, so the pin keeps its safe level.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         fault_reg <= 1'b0;
      end else if (!pwm) begin
         fault_reg <= 1'b0;
      end else if (|new_flt) begin
         fault_reg <= 1'b1;
      end else if (ctrl2_reg[C2_HOLD]) begin
         if (ctrl1_reg[C1_FSTAT_LSB +: 3] == 3'h0) fault_reg <= 1'b0;
      end else if (per_hit && (fsrc & ctrl1_reg[C1_FEN_LSB +: 3]) == 3'h0) begin
         fault_reg <= 1'b0;
      end
   end

   // Pin level, direction, interrupt flag and period event.
   // Registered so the pad never sees decode glitches, at one clock of delay.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pin_reg <= 1'b0;
         oe_reg <= 1'b0;
         irq_reg <= 1'b0;
         per_ev_reg <= 1'b0;
      end else begin
         if (mode == M_OFF) pin_reg <= 1'b0;
         else if (fault_reg) pin_reg <= ctrl2_reg[C2_FLT_LVL];
         else pin_reg <= (pwm ? pwm_wave : comp_reg) ^ ctrl2_reg[C2_INV];
         oe_reg <= !ctrl2_reg[C2_TRIS] || (fault_reg && ctrl2_reg[C2_FORCE]);
         irq_reg <= ((mode == M_SS_RISE || mode == M_SS_FALL || mode == M_TOGGLE) && pri_hit)
                    || ((mode == M_DC_ONE || mode == M_DC_CONT) && sec_hit && dc_reg == DC_WAIT_SEC);
         per_ev_reg <= per_hit;
      end
   end

   assign o_compare_output_pin = pin_reg;
   assign o_compare_output_pin_oe = oe_reg;
   assign o_compare_irq_flag = irq_reg;
   assign o_period_event = per_ev_reg;
   assign o_cascade_enable = ctrl2_reg[C2_CASCADE];
endmodule
`default_nettype wire

// >>> test/ocp_channel_sva.sv
// Purpose: Port-level checks for the compare channel.
// Assumes: One clock, synchronous active-low reset.
// Notes: Mode and invert are shadowed as each bus write lands.
`timescale 1ns/1ps
`default_nettype none
module ocp_channel_sva
   import ocp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic o_compare_output_pin,
   input wire logic o_compare_irq_flag,
   input wire logic o_period_event
);
   logic [7:0] a_q;
   logic [15:0] d_q;
   logic [2:0] mode_q;
   logic inv_q, bv_q;
   // Keep the address and data of the write in flight.
   always_ff @(posedge i_clk) begin
      bv_q <= o_bvalid;
      if (i_awvalid && o_awready) a_q <= i_awaddr;
      if (i_wvalid && o_wready) d_q <= i_wdata[15:0];
   end
   // Commit the copy as the write lands, the edge after the answer rises.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         mode_q <= 3'h0;
         inv_q <= 1'b0;
      end else if (o_bvalid && !bv_q && o_bresp == RESP_OKAY) begin
         if (a_q == OFF_CTRL1) mode_q <= d_q[2:0];
         if (a_q == OFF_CTRL2) inv_q <= d_q[C2_INV];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   property p_wr_answer; s_wr_taken |-> ##[1:2] o_bvalid; endproperty
   property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
   property p_rd_answer; i_arvalid && o_arready |=> o_rvalid; endproperty
   property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
   property p_r_done; o_rvalid && i_rready |=> !o_rvalid; endproperty
   property p_per_gap; o_period_event |=> !o_period_event [*3]; endproperty
   property p_irq_pulse; o_compare_irq_flag |=> !o_compare_irq_flag; endproperty
   property p_irq_pwm; (mode_q[2:1] == 2'b11) [*3] |-> !o_compare_irq_flag; endproperty
   property p_off_low; (mode_q == 3'h0 && !inv_q) [*3] |-> !o_compare_output_pin; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_r_done: assert property (p_r_done) else $error("read answer repeated");
   a_per_gap: assert property (p_per_gap) else $error("period too short");
   a_irq_pulse: assert property (p_irq_pulse) else $error("flag too long");
   a_irq_pwm: assert property (p_irq_pwm) else $error("flag in pwm");
   a_off_low: assert property (p_off_low) else $error("pin high while off");
endmodule
`default_nettype wire

// >>> test/ocp_load_model.sv
// Purpose: Fault pins and event sources beside the channel.
// Assumes: Requests come from the bench on clock edges.
// Notes: Slow mode delays fault levels by three clocks.
`timescale 1ns/1ps
`default_nettype none
module ocp_load_model
   import ocp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic i_fault_req,
   input wire logic i_ext1_req,
   output ocp_src_t o_src,
   output logic o_fault_pin_a,
   output logic o_fault_pin_b
);
   logic [2:0] dly = 3'h0;
   logic ext_q = 1'b0;
   // Fault pin A follows the request, late when slow; pin B stays low.
   always_ff @(posedge i_clk) begin
      dly <= {dly[1:0], i_fault_req};
      o_fault_pin_a <= i_slow ? dly[2] : i_fault_req;
      o_fault_pin_b <= 1'b0;
   end
   // A held request gives one single-clock event pulse.
   always_ff @(posedge i_clk) begin
      ext_q <= i_ext1_req;
      o_src <= {22'h0, i_ext1_req && !ext_q, 1'b0};
   end
endmodule
`default_nettype wire

// >>> test/ocp_channel_tb.sv
// Purpose: Self-checking bench for the compare channel.
// Assumes: 10 MHz clock, registers over AXI4-Lite.
// Notes: Waveforms are measured between period events.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module ocp_channel_tb;
   import ocp_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd, got, seed = 32'ha73ace0f;
   logic [1:0] br, rr, resp;
   logic awr, wr_rdy, bv, arr, rv, pin, oe, irq, pev, fa, fb, casc;
   logic fq = 1'b0, xq = 1'b0, slow = 1'b0;
   ocp_src_t src;
   int err_total = 0, checks_done = 0, cyc = 0;
   int chg, hi, nirq, ncyc, per, sec;
   int q_chg[$] = '{0, 0, 3, 0, 6};
   int q_irq[$] = '{3, 3, 3, 0, 3};
   int q_pin[$] = '{1, 0, 2, 0, 2};
   ocp_channel u_dut (.i_clk(clk), .i_nrst(nrst), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
      .i_wvalid(wv), .o_wready(wr_rdy), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bready),
      .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rready),
      .o_rdata(rd), .o_rresp(rr), .i_src(src), .i_fault_pin_a(fa), .i_fault_pin_b(fb),
      .o_compare_output_pin(pin), .o_compare_output_pin_oe(oe), .o_compare_irq_flag(irq),
      .o_period_event(pev), .o_cascade_enable(casc));
   ocp_load_model u_load (.i_clk(clk), .i_slow(slow), .i_fault_req(fq), .i_ext1_req(xq), .o_src(src),
      .o_fault_pin_a(fa), .o_fault_pin_b(fb));
   // Free-running clock.
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Writes one word; each channel is released once taken, bready stays up until the answer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, done;
      done = 1'b0;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      bready <= 1'b1;
      while (!done) begin
         // Levels seen at the falling edge are those the next rising edge samples.
         @(negedge clk);
         ta = awv && awr;
         tw = wv && wr_rdy;
         done = bv;
         resp = br;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (done) bready <= 1'b0;
      end
   endtask
   // Reads one word; rready rises with the address and falls at the edge that takes the data.
   task automatic rd_reg(input logic [7:0] a);
      logic ta, done;
      done = 1'b0;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         ta = arv && arr;
         done = rv;
         resp = rr;
         got = rd;
         @(posedge clk);
         if (ta) arv <= 1'b0;
         if (done) rready <= 1'b0;
      end
   endtask
   // Counts edges, high clocks, flags and clocks over np periods.
   task automatic meas(input int np);
      int pe;
      logic last;
      pe = 0; chg = 0; hi = 0; nirq = 0; ncyc = 0;
      @(negedge clk);
      while (pev !== 1'b1) @(negedge clk);
      last = pin;
      while (pe < np) begin
         @(negedge clk);
         chg += int'(pin !== last);
         last = pin;
         hi += int'(pin === 1'b1);
         nirq += int'(irq === 1'b1);
         pe += int'(pev === 1'b1);
         ncyc++;
      end
   endtask
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         wrap_up();
      end
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(OFF_CTRL1);
      `CHK("ctrl1", 32'h0, got)
      rd_reg(OFF_CTRL2);
      `CHK("ctrl2", 32'h0000000c, got)
      rd_reg(8'h18);
      `CHK("rresp", RESP_SLVERR, resp)
      wr(8'h18, 32'h1);
      `CHK("bresp", RESP_SLVERR, resp)
      $display("test registers done");
      wr(OFF_PER, 32'h7);
      wr(OFF_PRI, 32'h2);
      wr(OFF_SEC, 32'h5);
      for (int m = 1; m < 6; m++) begin
         wr(OFF_CTRL1, 32'(m));
         meas(2);
         meas(3);
         `CHK("period", 96, ncyc)
         `CHK("edges", q_chg[m-1], chg)
         `CHK("flags", q_irq[m-1], nirq)
         if (q_pin[m-1] < 2) `CHK("level", 1'(q_pin[m-1]), pin)
      end
      $display("test compare modes done");
      seed = lfsr(seed);
      per = 3 + int'(seed[1:0]);
      sec = 1 + int'(seed[10:8]) % per;
      wr(OFF_PER, 32'(per));
      wr(OFF_SEC, 32'(sec));
      wr(OFF_PRI, 32'h1);
      wr(OFF_CTRL2, 32'h041f);
      wr(OFF_CTRL1, 32'h6);
      meas(2);
      meas(2);
      `CHK("pwm period", 8 * (per + 1), ncyc)
      `CHK("edge high", 2 * (4 * sec + 2), hi)
      `CHK("pwm flags", 0, nirq)
      wr(OFF_CTRL2, 32'h001f);
      wr(OFF_CTRL1, 32'h7);
      meas(2);
      meas(2);
      `CHK("centre high", 8 * (sec - 1), hi)
      wr(OFF_CTRL2, 32'h101f);
      meas(2);
      meas(2);
      `CHK("invert high", 8 * (per + 2 - sec), hi)
      $display("test pwm done");
      wr(OFF_SEC, 32'h0);
      wr(OFF_CTRL2, 32'h603f);
      wr(OFF_CTRL1, 32'h86);
      meas(1);
      `CHK("oe idle", 1'b0, oe)
      @(posedge clk);
      slow <= 1'b1;
      fq <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      `CHK("fault pin", 1'b1, pin)
      `CHK("fault oe", 1'b1, oe)
      rd_reg(OFF_STAT);
      `CHK("fault mode", 1'b1, got[ST_FAULT])
      rd_reg(OFF_CTRL1);
      `CHK("fault status", 1'b1, got[4])
      @(posedge clk);
      fq <= 1'b0;
      meas(2);
      rd_reg(OFF_STAT);
      `CHK("fault end", 1'b0, got[ST_FAULT])
      wr(OFF_CTRL1, 32'h86);
      rd_reg(OFF_CTRL1);
      `CHK("status clear", 1'b0, got[4])
      wr(OFF_CTRL1, 32'h83);
      slow <= 1'b0;
      fq <= 1'b1;
      repeat (8) @(posedge clk);
      fq <= 1'b0;
      rd_reg(OFF_CTRL1);
      `CHK("no pwm fault", 1'b0, got[4])
      $display("test fault done");
      wr(OFF_SEC, 32'h2);
      for (int c = 1; c >= 0; c--) begin
         wr(OFF_CTRL2, 32'h009e);
         wr(OFF_CTRL1, 32'h3 | 32'(c << 3));
         xq <= 1'b1;
         @(posedge clk);
         xq <= 1'b0;
         repeat (80) @(posedge clk);
         rd_reg(OFF_CTRL2);
         `CHK("trig status", c == 0, got[C2_TRIG_STAT])
      end
      $display("test trigger done");
      wr(OFF_CTRL2, 32'h0100);
      `CHK("cascade", 1'b1, casc)
      wr(OFF_CTRL1, 32'h0);
      repeat (20) @(posedge clk);
      rd_reg(OFF_STAT);
      `CHK("off state", 17'h0, got[16:0])
      $display("test off done");
      wrap_up();
   end
endmodule
bind ocp_channel ocp_channel_sva u_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_compare_output_pin(o_compare_output_pin),
   .o_compare_irq_flag(o_compare_irq_flag), .o_period_event(o_period_event));
`default_nettype wire
